// file: pkg/srcir_pkg.sv
// Package for the source interrupt router: map, widths, reset values
`default_nettype none
package srcir_pkg;
    localparam int unsigned SRC_W = 25;
    localparam int unsigned DST_N = 4;
    localparam int unsigned ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_RAW = 8'h00;
    localparam logic [7:0] OFF_TRIG = 8'h04;
    localparam logic [7:0] OFF_FORCE = 8'h08;
    localparam logic [7:0] OFF_LATCH = 8'h0c;
    localparam logic [7:0] OFF_BYPASS = 8'h10;
    localparam logic [7:0] OFF_ENA = 8'h14;
    localparam logic [7:0] OFF_ENA_CLR = 8'h18;
    localparam logic [7:0] OFF_ENA_SET = 8'h1c;
    localparam logic [7:0] OFF_ACTIVE = 8'h20;
    localparam logic [7:0] OFF_MAP0 = 8'h24;
    localparam logic [7:0] OFF_DACT0 = 8'h34;
    localparam logic [7:0] OFF_STRIDE = 8'h04;
    // Reset values
    localparam logic [24:0] RST_TRIG = 25'h0000000;
    localparam logic [24:0] RST_BYPASS = 25'h0000001;
    localparam logic [24:0] RST_ENA = 25'h0000000;
    localparam logic [24:0] RST_MAP = 25'h0000000;
    localparam logic [24:0] RST_LATCH = 25'h0000000;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] resp;
        logic [31:0] data;
    } srcir_rd_t;
endpackage : srcir_pkg
`default_nettype wire

// file: verilog/srcir_top.sv
// Source interrupt router with AXI4-Lite register slave
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
module srcir_top #(
    parameter int unsigned SRC_W = srcir_pkg::SRC_W,
    parameter int unsigned DST_N = srcir_pkg::DST_N
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic ARST_N_I,
    // Interrupt sources, polarity already corrected
    input wire logic [SRC_W-1:0] SRC_IRQ_I,
    // Destination interrupts
    output logic [DST_N-1:0] DST_IRQ_O,
    // AXI4-Lite write address
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic [2:0] S_AXI_AWPROT_I,
    // AXI4-Lite write data
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    // AXI4-Lite write response
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    output logic [1:0] S_AXI_BRESP_O,
    // AXI4-Lite read address
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic [2:0] S_AXI_ARPROT_I,
    // AXI4-Lite read data
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O
);
    // ---------------------------------------------------------------
    // Source synchronisers
    // ---------------------------------------------------------------
    logic [SRC_W-1:0] src_m_q;
    logic [SRC_W-1:0] raw_q;
    logic [SRC_W-1:0] raw_prev_q;
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            src_m_q <= '0;
            raw_q <= '0;
            raw_prev_q <= '0;
        end else begin
            src_m_q <= SRC_IRQ_I;
            raw_q <= src_m_q;
            raw_prev_q <= raw_q;
        end
    end

    // ---------------------------------------------------------------
    // Write channel capture
    // ---------------------------------------------------------------
    logic aw_full_q;
    logic w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    assign wr_fire = aw_full_q && w_full_q && !S_AXI_BVALID_O;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_I;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_full_q <= 1'b1;
                w_data_q <= S_AXI_WDATA_I;
                w_strb_q <= S_AXI_WSTRB_I;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
        end else begin
            S_AXI_AWREADY_O <= !aw_full_q && !(S_AXI_AWVALID_I && S_AXI_AWREADY_O);
            S_AXI_WREADY_O <= !w_full_q && !(S_AXI_WVALID_I && S_AXI_WREADY_O);
        end
    end

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function automatic logic [4:0] dec_idx(input logic [7:0] a);
        // Word index 0..16 for mapped words, 31 when unmapped
        if (a[1:0] != 2'h0
                || a > 8'(srcir_pkg::OFF_DACT0 + (DST_N - 1) * srcir_pkg::OFF_STRIDE)) begin
            return 5'h1f;
        end
        return a[6:2];
    endfunction : dec_idx

    logic [4:0] wr_idx;
    logic wr_full_word;
    assign wr_idx = dec_idx(aw_addr_q);
    assign wr_full_word = (w_strb_q == 4'hf);
    logic [SRC_W-1:0] wbits;
    assign wbits = w_data_q[SRC_W-1:0];

    function automatic logic hit(input logic [4:0] idx, input logic [7:0] off);
        return idx == off[6:2];
    endfunction : hit

    logic wr_trig, wr_force, wr_latch, wr_bypass, wr_ena, wr_ena_clr, wr_ena_set;
    assign wr_trig = wr_fire && wr_full_word && hit(wr_idx, srcir_pkg::OFF_TRIG);
    assign wr_force = wr_fire && wr_full_word && hit(wr_idx, srcir_pkg::OFF_FORCE);
    assign wr_latch = wr_fire && wr_full_word && hit(wr_idx, srcir_pkg::OFF_LATCH);
    assign wr_bypass = wr_fire && wr_full_word && hit(wr_idx, srcir_pkg::OFF_BYPASS);
    assign wr_ena = wr_fire && wr_full_word && hit(wr_idx, srcir_pkg::OFF_ENA);
    assign wr_ena_clr = wr_fire && wr_full_word && hit(wr_idx, srcir_pkg::OFF_ENA_CLR);
    assign wr_ena_set = wr_fire && wr_full_word && hit(wr_idx, srcir_pkg::OFF_ENA_SET);

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    logic [SRC_W-1:0] trig_q;
    logic [SRC_W-1:0] bypass_q;
    logic [SRC_W-1:0] ena_q;
    logic [SRC_W-1:0] map_q [DST_N];

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            trig_q <= srcir_pkg::RST_TRIG;
            bypass_q <= srcir_pkg::RST_BYPASS;
        end else begin
            if (wr_trig) trig_q <= wbits;
            if (wr_bypass) bypass_q <= wbits;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ena_q <= srcir_pkg::RST_ENA;
        end else if (wr_ena) begin
            ena_q <= wbits;
        end else if (wr_ena_clr) begin
            ena_q <= ena_q & ~wbits;
        end else if (wr_ena_set) begin
            ena_q <= ena_q | wbits;
        end
    end

    for (genvar d = 0; d < DST_N; d++) begin : g_map
        logic wr_map;
        assign wr_map = wr_fire && wr_full_word
            && (wr_idx == 5'(srcir_pkg::OFF_MAP0[6:2] + d));
        always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
                map_q[d] <= srcir_pkg::RST_MAP;
            end else if (wr_map) begin
                map_q[d] <= wbits;
            end
        end
    end

    // ---------------------------------------------------------------
    // Latched status
    // ---------------------------------------------------------------
    logic [SRC_W-1:0] latch_q;
    logic [SRC_W-1:0] event_set;
    logic [SRC_W-1:0] latch_clr;
    // Level: raw high; edge: raw changed; plus one-shot force
    assign event_set = (~trig_q & raw_q)
        | (trig_q & (raw_q ^ raw_prev_q))
        | (wr_force ? wbits : '0);
    assign latch_clr = wr_latch ? wbits : '0;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            latch_q <= srcir_pkg::RST_LATCH;
        end else begin
            latch_q <= (latch_q & ~latch_clr) | event_set;
        end
    end

    // ---------------------------------------------------------------
    // Active sources and destinations
    // ---------------------------------------------------------------
    logic [SRC_W-1:0] active;
    assign active = ((bypass_q & raw_q)
        | (~bypass_q & latch_q)) & ena_q;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            DST_IRQ_O <= '0;
        end else begin
            for (int d = 0; d < DST_N; d++) begin
                DST_IRQ_O[d] <= |(active & map_q[d]);
            end
        end
    end

    // ---------------------------------------------------------------
    // Write response
    // ---------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= srcir_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O <= (wr_idx == 5'h1f) ? srcir_pkg::RESP_SLVERR
                : srcir_pkg::RESP_OKAY;
        end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    function automatic srcir_pkg::srcir_rd_t rd_word(input logic [4:0] idx,
            input logic [SRC_W-1:0] raw, input logic [SRC_W-1:0] trg,
            input logic [SRC_W-1:0] lat, input logic [SRC_W-1:0] byp,
            input logic [SRC_W-1:0] ena, input logic [SRC_W-1:0] act,
            input logic [DST_N*SRC_W-1:0] maps);
        srcir_pkg::srcir_rd_t r;
        logic [SRC_W-1:0] v;
        r = '{resp: srcir_pkg::RESP_OKAY, data: 32'h0};
        v = '0;
        if (idx == srcir_pkg::OFF_RAW[6:2]) v = raw;
        else if (idx == srcir_pkg::OFF_TRIG[6:2]) v = trg;
        else if (idx == srcir_pkg::OFF_LATCH[6:2]) v = lat;
        else if (idx == srcir_pkg::OFF_BYPASS[6:2]) v = byp;
        else if (idx == srcir_pkg::OFF_ENA[6:2]) v = ena;
        else if (idx == srcir_pkg::OFF_ACTIVE[6:2]) v = act;
        else if (idx >= srcir_pkg::OFF_MAP0[6:2] && idx < srcir_pkg::OFF_DACT0[6:2])
            v = maps[(idx - srcir_pkg::OFF_MAP0[6:2]) * SRC_W +: SRC_W];
        else if (idx >= srcir_pkg::OFF_DACT0[6:2]
                && idx < 5'(srcir_pkg::OFF_DACT0[6:2] + DST_N))
            v = act & maps[(idx - srcir_pkg::OFF_DACT0[6:2]) * SRC_W +: SRC_W];
        else if (idx == 5'h1f) r.resp = srcir_pkg::RESP_SLVERR;
        r.data = {{(32 - SRC_W){1'b0}}, v};
        return r;
    endfunction : rd_word

    logic [DST_N*SRC_W-1:0] maps_flat;
    for (genvar d = 0; d < DST_N; d++) begin : g_flat
        assign maps_flat[d*SRC_W +: SRC_W] = map_q[d];
    end

    srcir_pkg::srcir_rd_t rd_res;
    assign rd_res = rd_word(dec_idx(S_AXI_ARADDR_I), raw_q, trig_q, latch_q,
        bypass_q, ena_q, active, maps_flat);

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= '0;
            S_AXI_RRESP_O <= srcir_pkg::RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= !S_AXI_RVALID_O && !(S_AXI_ARVALID_I && S_AXI_ARREADY_O);
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O <= rd_res.data;
                S_AXI_RRESP_O <= rd_res.resp;
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_level_hold;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        (!trig_q[1] && raw_q[1]) |=> latch_q[1];
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level bit not held");

    property p_edge_set;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        (trig_q[2] && (raw_q[2] != raw_prev_q[2])) |=> latch_q[2];
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("edge not latched");

    property p_force;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        wr_force |=> ((latch_q & $past(wbits)) == $past(wbits));
    endproperty
    a_force: assert property (p_force) else $error("force did not set");

    property p_sticky;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        !wr_latch |=> ((latch_q & $past(latch_q)) == $past(latch_q));
    endproperty
    a_sticky: assert property (p_sticky) else $error("latched bit dropped");

    property p_ena_clr;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        wr_ena_clr |=> (ena_q == ($past(ena_q) & ~$past(wbits)));
    endproperty
    a_ena_clr: assert property (p_ena_clr) else $error("enable clear wrong");

    property p_ena_set;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        wr_ena_set |=> (ena_q == ($past(ena_q) | $past(wbits)));
    endproperty
    a_ena_set: assert property (p_ena_set) else $error("enable set wrong");

    property p_dst;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        ##1 DST_IRQ_O[0] == |($past(active) & $past(map_q[0]));
    endproperty
    a_dst: assert property (p_dst) else $error("destination 0 wrong");

    property p_gate;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        !ena_q[3] |-> !active[3];
    endproperty
    a_gate: assert property (p_gate) else $error("disabled source active");

    property p_bypass;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        (bypass_q[4] && ena_q[4]) |-> (active[4] == raw_q[4]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not raw");

    property p_w1c;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        wr_latch |=> ((latch_q & $past(wbits & ~event_set)) == '0);
    endproperty
    a_w1c: assert property (p_w1c) else $error("write-one clear failed");

    property p_dst_last;
        @(posedge CORE_CLK_I) disable iff (!ARST_N_I)
        ##1 DST_IRQ_O[DST_N-1] == |($past(active) & $past(map_q[DST_N-1]));
    endproperty
    a_dst_last: assert property (p_dst_last) else $error("last destination wrong");

    c_force: cover property (@(posedge CORE_CLK_I) wr_force);
    c_clear: cover property (@(posedge CORE_CLK_I) wr_latch && |latch_q);
    c_dst: cover property (@(posedge CORE_CLK_I) |DST_IRQ_O);
    c_edge: cover property (@(posedge CORE_CLK_I) |(trig_q & (raw_q ^ raw_prev_q)));
    c_bypass: cover property (@(posedge CORE_CLK_I) |(bypass_q & raw_q & ena_q));
endmodule : srcir_top
`default_nettype wire

// file: tb/srcir_core_model.sv
// Processor core model watching the four destination lines
`default_nettype none
module srcir_core_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Destination lines from the router
    input wire logic [3:0] irq_i,
    // Sampled levels and raised-ever flags
    output logic [3:0] level_o,
    output logic [3:0] taken_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_o <= 4'h0;
            taken_o <= 4'h0;
        end else begin
            level_o <= irq_i;
            taken_o <= taken_o | (irq_i & ~level_o);
        end
    end
endmodule : srcir_core_model
`default_nettype wire

// file: tb/source_interrupt_router_test.sv
// Self-checking testbench for the source interrupt router
`default_nettype none
module source_interrupt_router_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [24:0] src = '0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic [7:0] awa = '0, ara = '0;
    logic [31:0] wd = '0;
    wire logic awr, wrdy, bv, arr, rv;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdat;
    wire logic [3:0] dst, lvl, taken;
    int bad_count = 0, n_checks = 0, seed = 188;
    logic [31:0] rdv;
    logic [1:0] rsp;
    logic [24:0] r, f, b, a, s, c, e, lat, act;
    logic [24:0] m [4];
    logic [3:0] exp_d, any_d = 4'h0;

    always #25 clk = ~clk;

    srcir_top dut_u (
        .CORE_CLK_I(clk), .ARST_N_I(rst_n), .SRC_IRQ_I(src), .DST_IRQ_O(dst),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
        .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_BVALID_O(bv),
        .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv),
        .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(3'h0),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rdat),
        .S_AXI_RRESP_O(rresp)
    );

    srcir_core_model core_u (
        .clk_i(clk), .rst_n_i(rst_n), .irq_i(dst), .level_o(lvl), .taken_o(taken)
    );

    // ----------------------------------------
    // Expectation, comparison and closing
    // ----------------------------------------
    function automatic logic [24:0] exp_act(input logic [24:0] l, raw, byp, en);
        return ((l & ~byp) | (raw & byp)) & en;
    endfunction : exp_act

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Register bus master
    // ----------------------------------------
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk);
        awv <= 1'b1;
        awa <= ad;
        wv <= 1'b1;
        wd <= d;
        br <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        br <= 1'b0;
        rsp = bresp;
        if (n == 40) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wr

    task automatic rd(input logic [7:0] ad);
        int n;
        @(posedge clk);
        arv <= 1'b1;
        ara <= ad;
        rr <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rr <= 1'b0;
        rdv = rdat;
        rsp = rresp;
        if (n == 40) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : rd

    task automatic rc(input logic [7:0] ad, input logic [24:0] exp);
        rd(ad);
        chk({rsp, rdv}, {srcir_pkg::RESP_OKAY, 7'h0, exp});
    endtask : rc

    task automatic set_src(input logic [24:0] v);
        @(posedge clk);
        src <= v;
        repeat (5) @(posedge clk);
    endtask : set_src

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rc(srcir_pkg::OFF_TRIG, '0);
        rc(srcir_pkg::OFF_BYPASS, 25'h0000001);
        rc(srcir_pkg::OFF_ENA, '0);
        rc(srcir_pkg::OFF_LATCH, '0);
        for (int i = 0; i < 4; i++) rc(srcir_pkg::OFF_MAP0 + 8'(4 * i), '0);
        rd(8'h44);
        chk({rsp, 32'h0}, {srcir_pkg::RESP_SLVERR, 32'h0});
        wr(8'h44, 32'hffffffff);
        chk({rsp, 32'h0}, {srcir_pkg::RESP_SLVERR, 32'h0});
        // Level mode, random sources, masks and routes
        for (int k = 0; k < 6; k++) begin
            r = 25'($random(seed));
            f = 25'($random(seed));
            b = 25'($random(seed));
            a = 25'($random(seed));
            s = 25'($random(seed));
            c = 25'($random(seed));
            if (k == 0) begin
                r = '1;
                c = '1;
            end
            for (int i = 0; i < 4; i++) m[i] = 25'($random(seed));
            set_src(r);
            wr(srcir_pkg::OFF_LATCH, 32'h01ffffff);
            wr(srcir_pkg::OFF_FORCE, {7'h0, f});
            wr(srcir_pkg::OFF_BYPASS, {7'h0, b});
            wr(srcir_pkg::OFF_ENA, {7'h0, a});
            wr(srcir_pkg::OFF_ENA_SET, {7'h0, s});
            wr(srcir_pkg::OFF_ENA_CLR, {7'h0, c});
            for (int i = 0; i < 4; i++) wr(srcir_pkg::OFF_MAP0 + 8'(4 * i), {7'h0, m[i]});
            lat = r | f;
            e = (a | s) & ~c;
            act = exp_act(lat, r, b, e);
            rc(srcir_pkg::OFF_RAW, r);
            rc(srcir_pkg::OFF_LATCH, lat);
            rc(srcir_pkg::OFF_FORCE, '0);
            rc(srcir_pkg::OFF_BYPASS, b);
            rc(srcir_pkg::OFF_ENA, e);
            rc(srcir_pkg::OFF_ACTIVE, act);
            for (int i = 0; i < 4; i++) begin
                rc(srcir_pkg::OFF_DACT0 + 8'(4 * i), act & m[i]);
                rc(srcir_pkg::OFF_MAP0 + 8'(4 * i), m[i]);
                exp_d[i] = |(act & m[i]);
            end
            any_d = any_d | exp_d;
            chk({30'h0, lvl}, {30'h0, exp_d});
        end
        // Latched bits outlive their source and ignore zero writes
        set_src('0);
        rc(srcir_pkg::OFF_LATCH, lat);
        wr(srcir_pkg::OFF_LATCH, 32'h0);
        rc(srcir_pkg::OFF_LATCH, lat);
        // Edge mode catches both directions and clears while high
        wr(srcir_pkg::OFF_TRIG, 32'h01ffffff);
        wr(srcir_pkg::OFF_LATCH, 32'h01ffffff);
        rc(srcir_pkg::OFF_TRIG, 25'h1ffffff);
        rc(srcir_pkg::OFF_LATCH, '0);
        r = 25'($random(seed)) | 25'h0000100;
        set_src(r);
        rc(srcir_pkg::OFF_LATCH, r);
        wr(srcir_pkg::OFF_LATCH, 32'h01ffffff);
        rc(srcir_pkg::OFF_LATCH, '0);
        set_src('0);
        rc(srcir_pkg::OFF_LATCH, r);
        chk({30'h0, taken}, {30'h0, any_d});
        tally_and_finish();
    end
endmodule : source_interrupt_router_test
`default_nettype wire
